/* verilog/twp_timer_wd.sv */
/*
  twp_timer_wd: 8-bit cycle counter and 8-bit watchdog counter sharing one
  programmable divider, used as prescaler or postscaler.
  assumes: CLOCK is the instruction-cycle clock; the core's requests and
  WD_TICK come from logic on CLOCK; COUNT_PIN is an asynchronous pin.
*/
//
// Behaviour
// R1 - count per cycle or per pin edge
// R2 - divider extends timer range to sixteen bits
// R3 - config bit 5 clear selects cycle clock
// R4 - config bit 5 set counts pin edges
// R5 - config bit 4 selects falling, else rising
// R6 - rollover from max to zero raises interrupt
// R7 - no sticky rollover flag is kept
// R8 - watchdog counter shares the same divider
// R9 - bit 3 set: watchdog drives divider postscaler
// R10 - bit 3 clear: divider output clocks timer
// R11 - three rate bits choose the ratio
// R12 - prescaled internal timer steps on divider pulses
// R13 - divider serves exactly one user at once
// R14 - divider count has no software access
// R15 - watchdog expiry resets the device
// R16 - add-w return adds working register to count
// R17 - ratios 2..256 timer, 1..128 watchdog
// R18 - watchdog clear zeroes counter and its divider
`timescale 1ns/1ps
module twp_timer_wd
#(
  parameter int CNT_W = 8
)
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // configuration byte from the core
  input wire logic CFG_WRITE,
  input wire twp_pkg::twp_cfg_t CFG_DATA,
  output twp_pkg::twp_cfg_t CFG_VALUE,
  // timer count access from the core
  input wire twp_pkg::twp_cnt_req_t CNT_REQ,
  output logic [7:0] CNT_VALUE,
  output logic TMR_IRQ,
  // external count pin
  input wire logic COUNT_PIN,
  // watchdog
  input wire logic WD_ENABLE,
  input wire logic WD_TICK,
  input wire logic WD_CLEAR,
  output logic [7:0] WD_VALUE,
  output logic WD_RESET
);
  import twp_pkg::*;

  // the counters are fixed at one byte, matching the core's data path
  if (CNT_W != TWP_CNT_W)
  begin : g_bad_cnt_w
    $error("twp_timer_wd supports only CNT_W of 8");
  end

  twp_cfg_t cfg_reg;          // stored configuration byte
  twp_cfg_t cfg_next;
  logic [7:0] cnt_reg;        // timer count
  logic [7:0] cnt_next;
  logic irq_reg;              // one-cycle rollover request
  logic irq_next;
  logic [7:0] wd_reg;         // watchdog count
  logic [7:0] wd_next;
  logic wdrst_reg;            // one-cycle device reset request
  logic wdrst_next;

  logic pin_edge;             // qualified edge of the count pin
  logic src_tick;             // one event of the selected source
  logic tmr_inc;              // timer steps this cycle
  logic wd_step;              // watchdog steps this cycle
  logic wd_ovf;               // watchdog wraps this cycle
  logic expiry;               // watchdog time-out, after postscaling
  logic div_tick;             // input event of the divider
  logic div_clear;            // restart of the divider
  logic div_pulse;            // divider output
  logic [3:0] div_log2;       // divide ratio as power of two
  logic assign_change;        // configuration moves the divider

  // synchronised pin with the chosen polarity
  twp_edge u_edge
  (
    .clk(CLOCK),
    .rst(RST),
    .pin(COUNT_PIN),
    .fall_sel(cfg_reg.edge_fall), // R5
    .edge_pulse(pin_edge)
  );

  // one shared divider; no port reaches its count from outside
  twp_divider #(.W(TWP_DIV_W)) u_div // R14
  (
    .clk(CLOCK),
    .rst(RST),
    .tick(div_tick),
    .clear(div_clear),
    .log2(div_log2),
    .pulse(div_pulse)
  );

  // source: every cycle, or the counted pin edge
  always_comb
  begin
    if (cfg_reg.src_ext)
      src_tick = pin_edge; // R4
    else
      src_tick = 1'b1; // R3
  end

  // ratio: the rate field shifted up by one for the timer, so the
  // timer never runs undivided through the divider
  always_comb
  begin
    if (cfg_reg.assign_wd)
      div_log2 = {1'b0, cfg_reg.rate}; // R11 R17
    else
      div_log2 = 4'({1'b0, cfg_reg.rate} + TWP_TMR_LOG_OFS); // R11 R17
  end

  // divider routing: exactly one user feeds it and takes its pulses
  always_comb
  begin
    if (cfg_reg.assign_wd)
    begin
      div_tick = wd_ovf; // R9 R13
      tmr_inc = src_tick; // R13
      expiry = div_pulse; // R9
    end
    else
    begin
      div_tick = src_tick; // R10 R13
      tmr_inc = div_pulse; // R10 R12 R2
      expiry = wd_ovf; // R13
    end
  end

  // watchdog stepping; a software clear in the same cycle wins, since
  // its whole purpose is to push the time-out further away
  assign wd_step = WD_ENABLE && WD_TICK && !WD_CLEAR; // R8
  assign wd_ovf = wd_step && (wd_reg == TWP_CNT_MAX);

  // moving the divider from one user to the other starts it afresh, so
  // a half-full count never leaks into the new user
  assign assign_change = CFG_WRITE && (CFG_DATA.assign_wd != cfg_reg.assign_wd);

  // divider restarts: reassignment, watchdog clear, timer load, and an
  // undivided watchdog wrap. A postscaler pulse needs no clear, since the
  // step that makes it already leaves the masked low bits at zero. Reading
  // expiry here would feed the divider's own pulse back into its clear.
  always_comb
  begin
    div_clear = assign_change;
    if (WD_CLEAR && cfg_reg.assign_wd)
      div_clear = 1'b1; // R18
    if (CNT_REQ.wr && !cfg_reg.assign_wd)
      div_clear = 1'b1;
    if (wd_ovf && !cfg_reg.assign_wd)
      div_clear = 1'b1;
  end

  // configuration byte: loaded whole by the core
  always_comb
  begin
    cfg_next = cfg_reg;
    if (CFG_WRITE)
      cfg_next = CFG_DATA;
  end

  // timer count: a load beats the add-w return, which beats a plain step
  always_comb
  begin
    cnt_next = cnt_reg;
    if (CNT_REQ.wr)
      cnt_next = CNT_REQ.data;
    else if (CNT_REQ.add_w)
      cnt_next = 8'(cnt_reg + CNT_REQ.data + {7'h00, tmr_inc}); // R16
    else if (tmr_inc)
      cnt_next = 8'(cnt_reg + TWP_CNT_ONE); // R1
  end

  // rollover request: a pulse only, nothing is held for software to
  // clear; a load in the same cycle cancels the step and the request
  always_comb
  begin
    irq_next = tmr_inc && !CNT_REQ.wr && (cnt_reg == TWP_CNT_MAX); // R6 R7
  end

  // watchdog count: cleared by software or by its own time-out
  always_comb
  begin
    wd_next = wd_reg;
    if (WD_CLEAR || expiry)
      wd_next = TWP_CNT_RESET; // R18
    else if (wd_step)
      wd_next = 8'(wd_reg + TWP_CNT_ONE); // R8
  end

  // device reset request on expiry; the timer count is left alone
  always_comb
  begin
    wdrst_next = expiry; // R15
  end

  // register stage for all state of this block
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      cfg_reg <= twp_cfg_t'(TWP_CFG_RESET);
      cnt_reg <= TWP_CNT_RESET;
      irq_reg <= 1'b0;
      wd_reg <= TWP_CNT_RESET;
      wdrst_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      cnt_reg <= cnt_next;
      irq_reg <= irq_next;
      wd_reg <= wd_next;
      wdrst_reg <= wdrst_next;
    end
  end

  // outputs straight from flops
  assign CFG_VALUE = cfg_reg;
  assign CNT_VALUE = cnt_reg;
  assign TMR_IRQ = irq_reg;
  assign WD_VALUE = wd_reg;
  assign WD_RESET = wdrst_reg;

  // rollover from max to zero gives the request one cycle later
  a_irq_on_wrap: assert property (@(posedge CLOCK) disable iff (RST) // R6
    (tmr_inc && !CNT_REQ.wr && !CNT_REQ.add_w && cnt_reg == TWP_CNT_MAX)
    |=> (TMR_IRQ && CNT_VALUE == TWP_CNT_RESET))
    else $error("rollover did not raise the interrupt request");

  // the request never stands without a rollover and never lingers
  a_irq_pulse_only: assert property (@(posedge CLOCK) disable iff (RST) // R7
    TMR_IRQ |-> ($past(cnt_reg) == TWP_CNT_MAX && $past(tmr_inc))
    ##1 (!TMR_IRQ || $past(cnt_reg) == TWP_CNT_MAX))
    else $error("interrupt request held or raised without rollover");

  // internal source with the divider on the watchdog steps every cycle
  a_internal_step: assert property (@(posedge CLOCK) disable iff (RST) // R3
    (!cfg_reg.src_ext && cfg_reg.assign_wd && !CNT_REQ.wr && !CNT_REQ.add_w)
    |=> CNT_VALUE == 8'($past(CNT_VALUE) + TWP_CNT_ONE))
    else $error("internal source did not step the count");

  // external source without a pin edge leaves the count still
  a_ext_hold: assert property (@(posedge CLOCK) disable iff (RST) // R4
    (cfg_reg.src_ext && cfg_reg.assign_wd && !pin_edge && !CNT_REQ.wr && !CNT_REQ.add_w)
    |=> $stable(CNT_VALUE))
    else $error("external source moved the count without an edge");

  // prescaled internal timer never steps two cycles running
  a_prescale_gap: assert property (@(posedge CLOCK) disable iff (RST) // R12
    (!cfg_reg.src_ext && !cfg_reg.assign_wd && !CFG_WRITE && tmr_inc) |=> !tmr_inc)
    else $error("prescaled timer stepped on consecutive cycles");

  // divide-by-four prescale: three quiet cycles after one divider pulse
  a_prescale_min: assert property (@(posedge CLOCK) disable iff (RST) // R17
    (!cfg_reg.src_ext && !cfg_reg.assign_wd && cfg_reg.rate == 3'h1 && !CFG_WRITE && !CNT_REQ.wr
     && tmr_inc)
    |=> (!tmr_inc)[*3])
    else $error("divide by four stepped too early");

  // expiry comes only from a watchdog wrap, whichever way it is routed
  a_expiry_cause: assert property (@(posedge CLOCK) disable iff (RST) // R9
    WD_RESET |-> ($past(wd_ovf) && WD_VALUE == TWP_CNT_RESET))
    else $error("device reset without watchdog wrap");

  // undivided watchdog expires right at its wrap
  a_wd_direct: assert property (@(posedge CLOCK) disable iff (RST) // R15
    (!cfg_reg.assign_wd && wd_ovf) |=> WD_RESET)
    else $error("watchdog wrap did not reset the device");

  // software clear zeroes the watchdog and blocks expiry that cycle
  a_wd_clear: assert property (@(posedge CLOCK) disable iff (RST) // R18
    WD_CLEAR |=> (WD_VALUE == TWP_CNT_RESET && !WD_RESET))
    else $error("watchdog clear did not take effect");

  // add-w return sums the working register into the count
  a_add_w: assert property (@(posedge CLOCK) disable iff (RST) // R16
    (CNT_REQ.add_w && !CNT_REQ.wr)
    |=> CNT_VALUE == 8'($past(CNT_VALUE) + $past(CNT_REQ.data) + {7'h00, $past(tmr_inc)}))
    else $error("add-w return gave a wrong count");

  // with the divider on the watchdog, every source event steps the timer
  // by exactly one, so no divider pulse can reach it
  a_one_user: assert property (@(posedge CLOCK) disable iff (RST) // R13
    (cfg_reg.assign_wd && src_tick && !CNT_REQ.wr && !CNT_REQ.add_w)
    |=> CNT_VALUE == 8'($past(CNT_VALUE) + TWP_CNT_ONE))
    else $error("divider reached the timer while given to the watchdog");

endmodule

/* shared/twp_pkg.sv */
/*
  twp_pkg: constants and carrier types shared by the timer / watchdog /
  divider block and its two helper modules.
  assumes: every file that uses it imports twp_pkg::* and runs on CLOCK.
*/
package twp_pkg;

  // widths of the counters and of the shared divider
  localparam int TWP_CNT_W = 8;
  localparam int TWP_DIV_W = 8;
  localparam int TWP_LOG_W = 4;

  // field positions inside the timer configuration byte
  localparam int TWP_BIT_SRC_EXT = 5;
  localparam int TWP_BIT_EDGE_FALL = 4;
  localparam int TWP_BIT_ASSIGN_WD = 3;
  localparam int TWP_BIT_RATE_LO = 0;

  // values after reset: configuration all ones, counters cleared
  localparam logic [7:0] TWP_CFG_RESET = 8'hFF;
  localparam logic [7:0] TWP_CNT_RESET = 8'h00;
  localparam logic [7:0] TWP_CNT_MAX = 8'hFF;
  localparam logic [7:0] TWP_CNT_ONE = 8'h01;

  // offset added to the rate field when the divider serves the timer
  localparam logic [3:0] TWP_TMR_LOG_OFS = 4'h1;

  // configuration byte, laid out at the documented bit positions
  typedef struct packed {
    logic [1:0] spare;      // bits 7..6, stored, no effect here
    logic src_ext;          // bit 5: count the external pin
    logic edge_fall;        // bit 4: count falling edges
    logic assign_wd;        // bit 3: divider serves the watchdog
    logic [2:0] rate;       // bits 2..0: divide ratio select
  } twp_cfg_t;

  // requests from the core that touch the timer count
  typedef struct packed {
    logic wr;               // load the count with data
    logic add_w;            // interrupt return that adds the working register
    logic [7:0] data;       // load value, or working register value
  } twp_cnt_req_t;

endpackage

/* verilog/twp_edge.sv */
/*
  twp_edge: brings the external count pin into the CLOCK domain and
  picks out the selected edge as a one-cycle pulse.
  assumes: the pin is asynchronous and slower than half the clock rate.
*/
`timescale 1ns/1ps
module twp_edge
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and polarity
  input wire logic pin,
  input wire logic fall_sel,
  // detected edge
  output logic edge_pulse
);
  import twp_pkg::*;

  logic sync1_reg;   // first stage, read only by the second
  logic sync2_reg;   // second stage, safe to use
  logic prev_reg;    // one cycle older copy for edge detection
  logic sync1_next;
  logic sync2_next;
  logic prev_next;

  // next values of the synchroniser chain
  always_comb
  begin
    sync1_next = pin;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  // register stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  // polarity choice; edges are counted only after two flops of settling
  assign edge_pulse = fall_sel ? (prev_reg & ~sync2_reg) : (sync2_reg & ~prev_reg); // R5

  a_edge_polarity: assert property (@(posedge clk) disable iff (rst) // R5
    edge_pulse |-> (fall_sel ? (!sync2_reg && $past(sync2_reg)) : (sync2_reg && !$past(sync2_reg))))
    else $error("edge pulse does not match the selected polarity");

endmodule

/* verilog/twp_divider.sv */
/*
  twp_divider: the shared power-of-two divider. It counts input ticks and
  emits one pulse every 2**log2 ticks.
  assumes: log2 never exceeds W; clear is a one-cycle request.
*/
`timescale 1ns/1ps
module twp_divider
#(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic clear,
  input wire logic [3:0] log2,
  // divided output
  output logic pulse
);
  import twp_pkg::*;

  logic [W-1:0] count_reg;   // divider count, never visible to software
  logic [W-1:0] count_next;
  logic [W-1:0] mask;        // low bits that must all be ones

  // the logic serves ratios up to 2**8
  if (W < 8)
  begin : g_bad_width
    $error("twp_divider needs W of at least 8");
  end

  // turns a log2 ratio into the all-ones mask of the low bits
  function automatic logic [W-1:0] ratio_mask(input logic [3:0] l);
    logic [W:0] one;
    one = {{W{1'b0}}, 1'b1} << l;
    return W'(one - {{W{1'b0}}, 1'b1});
  endfunction

  assign mask = ratio_mask(log2);
  // a clear in the same cycle swallows the tick, so no stray pulse
  assign pulse = tick && !clear && ((count_reg & mask) == mask);

  // next count: clear first, then step on each tick
  always_comb
  begin
    count_next = count_reg;
    if (clear)
      count_next = '0;
    else if (tick)
      count_next = W'(count_reg + {{(W-1){1'b0}}, 1'b1});
  end

  // register stage
  always_ff @(posedge clk)
  begin
    if (rst)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

endmodule

/* verification/twp_pin_model.sv */
/*
  twp_pin_model: far-side source of the external count pin.
  assumes: the bench asks for a level and holds it for several cycles.
*/
`timescale 1ns/1ps
module twp_pin_model
(
  // clock
  input wire logic clk,
  // level wanted by the bench
  input wire logic level_req,
  // pin toward the block
  output logic pin
);
  // pin starts low, the level the bench assumes; one process drives it
  logic pin_q = 1'b0;
  assign pin = pin_q;
  // the pin moves 3 ns after an edge, so it never lines up with sampling
  always @(posedge clk)
  begin
    pin_q <= #3 level_req;
  end
endmodule

/* verification/twp_timer_wd_tb_top.sv */
/*
  twp_timer_wd_tb_top: self-checking bench for the timer / watchdog block.
  assumes: inputs move 1 ns after the rising edge; no feedback of WD_RESET.
*/
`timescale 1ns/1ps
module twp_timer_wd_tb_top;
  import twp_pkg::*;
  // stimulus and observed signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cfg_write = 1'b0;
  twp_cfg_t cfg_data = 8'h00;
  twp_cfg_t cfg_value;
  twp_cnt_req_t cnt_req = '0;
  logic [7:0] cnt_value;
  logic tmr_irq;
  logic count_pin;
  logic pin_level = 1'b0;
  logic wd_enable = 1'b0;
  logic wd_tick = 1'b0;
  logic wd_clear = 1'b0;
  logic [7:0] wd_value;
  logic wd_reset;
  // bookkeeping
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // 100 MHz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  twp_timer_wd #(.CNT_W(8)) twp_timer_wd_i (
    .CLOCK(clock), .RST(rst), .CFG_WRITE(cfg_write), .CFG_DATA(cfg_data),
    .CFG_VALUE(cfg_value), .CNT_REQ(cnt_req), .CNT_VALUE(cnt_value),
    .TMR_IRQ(tmr_irq), .COUNT_PIN(count_pin), .WD_ENABLE(wd_enable),
    .WD_TICK(wd_tick), .WD_CLEAR(wd_clear), .WD_VALUE(wd_value), .WD_RESET(wd_reset));

  twp_pin_model twp_pin_model_i (.clk(clock), .level_req(pin_level), .pin(count_pin));

  // closing report, reached from the main sequence or the hang guard
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard: the whole run needs well under 10000 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  // step n edges and land 1 ns after the last one
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one comparison; 16 bits wide so divider ratios fit too
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // write the configuration byte and read it back
  task automatic set_cfg(input logic ext, input logic fall, input logic wd, input logic [2:0] rate);
    cfg_data = {2'b00, ext, fall, wd, rate};
    cfg_write = 1'b1;
    cyc();
    cfg_write = 1'b0;
    check(cfg_value, cfg_data, "config readback");
  endtask

  // load the count; a load also clears a timer-side divider
  task automatic load(input logic [7:0] v);
    cnt_req = '{wr: 1'b1, add_w: 1'b0, data: v};
    cyc();
    cnt_req = '0;
  endtask

  // cycles until the count shows v, bounded
  task automatic wait_cnt(input logic [7:0] v, output int n);
    n = 0;
    while (cnt_value !== v && n < 600)
    begin
      cyc();
      n++;
    end
  endtask

  // n watchdog ticks, every other cycle; counts expiry pulses seen
  task automatic wd_ticks(input int n, output int hits);
    hits = 0;
    repeat (n)
    begin
      wd_tick = 1'b1;
      cyc();
      wd_tick = 1'b0;
      hits += (wd_reset === 1'b1);
      cyc();
      hits += (wd_reset === 1'b1);
    end
  endtask

  // software watchdog clear
  task automatic wd_kick();
    wd_clear = 1'b1;
    cyc();
    wd_clear = 1'b0;
    check(wd_value, 8'h00, "watchdog cleared");
  endtask

  // values held while reset is asserted
  task automatic t_reset();
    check(cfg_value, 8'hFF, "config reset");
    check(cnt_value, 8'h00, "count reset");
    check(wd_value, 8'h00, "watchdog reset value");
    check({tmr_irq, wd_reset}, 2'h0, "outputs idle in reset");
  endtask

  // per-cycle count, wrap and single interrupt pulse
  task automatic t_rollover();
    set_cfg(1'b0, 1'b0, 1'b1, 3'h0);
    load(8'hFF);
    check(cnt_value, 8'hFF, "load");
    cyc();
    check(cnt_value, 8'h00, "wrap to zero");
    check(tmr_irq, 1'b1, "interrupt on wrap");
    cyc();
    check(cnt_value, 8'h01, "one per cycle");
    check(tmr_irq, 1'b0, "interrupt not held");
  endtask

  // interrupt return that adds the working register, plus that cycle's step
  task automatic t_add_w();
    cnt_req = '{wr: 1'b1, add_w: 1'b0, data: 8'h10};
    cyc();
    cnt_req = '{wr: 1'b0, add_w: 1'b1, data: 8'h05};
    cyc();
    cnt_req = '0;
    check(cnt_value, 8'h16, "add working register");
  endtask

  // every prescaler ratio: cycles between two steps
  task automatic t_prescale();
    int n;
    for (int r = 0; r < 8; r++)
    begin
      set_cfg(1'b0, 1'b0, 1'b0, r[2:0]);
      load(8'h00);
      wait_cnt(8'h01, n);
      wait_cnt(8'h02, n);
      check(n[15:0], 16'h0001 << (r + 1), "prescale ratio");
    end
  endtask

  // pin edges of one polarity only are counted
  task automatic t_ext();
    logic [7:0] exp;
    for (int f = 0; f < 2; f++)
    begin
      set_cfg(1'b1, f[0], 1'b1, 3'h0);
      load(8'h00);
      exp = 8'h00;
      for (int k = 0; k < 4; k++)
      begin
        pin_level = ~pin_level;
        cyc(6);
        if (pin_level != f[0])
          exp++;
        check(cnt_value, exp, "pin edge count");
      end
    end
  endtask

  // watchdog without postscaler expires on its own wrap
  task automatic t_wd_direct();
    int hits;
    set_cfg(1'b0, 1'b0, 1'b0, 3'h0);
    wd_ticks(2, hits);
    check(wd_value, 8'h00, "disabled watchdog holds");
    wd_enable = 1'b1;
    wd_kick();
    wd_ticks(255, hits);
    check(hits[15:0], 16'h0000, "no early expiry");
    check(wd_value, 8'hFF, "watchdog count");
    wd_ticks(1, hits);
    check(hits[15:0], 16'h0001, "single expiry pulse");
    check(wd_value, 8'h00, "watchdog restarts");
  endtask

  // postscaler ratios 1 and 2; a clear also empties the postscaler
  task automatic t_wd_post();
    int hits;
    set_cfg(1'b0, 1'b0, 1'b1, 3'h0);
    wd_kick();
    wd_ticks(256, hits);
    check(hits[15:0], 16'h0001, "postscale by one");
    set_cfg(1'b0, 1'b0, 1'b1, 3'h1);
    wd_kick();
    wd_ticks(256, hits);
    check(hits[15:0], 16'h0000, "first wrap held back");
    wd_kick();
    wd_ticks(256, hits);
    check(hits[15:0], 16'h0000, "clear emptied postscaler");
    wd_ticks(256, hits);
    check(hits[15:0], 16'h0001, "postscale by two");
  endtask

  // main sequence: reset held 6 cycles, then scenarios
  initial
  begin
    cyc(6);
    t_reset();
    rst = 1'b0;
    cyc();
    t_rollover();
    t_add_w();
    t_prescale();
    t_ext();
    t_wd_direct();
    t_wd_post();
    give_verdict();
  end
endmodule
